// ===== rtl/hart_debug_trigger_csrs.v
// Purpose: Per-hart debug and trigger register unit with two breakpoints.
// Assumes: Core presents one CSR access per cycle with current mode.
// Notes:   Read data and fault are registered, valid one cycle later.
//
// Overview of operation
// RL1: Debug status, PC and scratch only in debug mode; trigger regs also machine.
// RL2: Select index chooses which breakpoint bank the data addresses reach.
// RL3: Select index is WARL; unimplemented indices are not kept.
// RL4: Software reads the type field to learn whether a trigger exists.
// RL5: Top nibble of data one is read-only type: 0 none, 2 match.
// RL6: Machine access to data regs of a debug-only trigger is illegal.
// RL7: Only debug mode reaches a trigger marked debug-only.
// RL8: Entry copies PC to debug PC; exit resumes from it.
// RL9: Debug scratch is left for debug ROM routines.
// RL10: Exactly two breakpoint triggers per hart.
// RL11: Data one is match control, two is address, three reserved.
// RL12: Control bits 0..2 enable load, store and fetch matching.
// RL13: Bits 3,4,6 enable user, supervisor, machine; bit 5 preserved.
// RL14: Bits 10..7 select the address match type.
// RL15: Bits 15..12 hold the action, reset to zero.
// RL16: Size, timing and select bits always read zero.
// RL17: Bits 26..21 read the fixed range limit four.
// RL18: Type field of a breakpoint always reads two.
// RL19: Action 0 raises breakpoint exception, action 1 enters debug mode.
// RL20: Chain on the lower breakpoint fires only when both match.
// RL21: Trailing address ones encode a naturally aligned range size.
// RL22: Debug-claimed breakpoints read type zero from machine mode.
// RL23: Select writes legalize to index zero or one.
// RL24: Match needs access type, privilege and address all true.
`timescale 1ns/100ps
`include "dbg_trig_defs.vh"

module hart_debug_trigger_csrs (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        srst_i,
  // CSR access from the core
  input  wire        csr_en_i,
  input  wire        csr_we_i,
  input  wire [2:0]  csr_sel_i,
  input  wire [31:0] csr_wdata_i,
  input  wire        debug_mode_i,
  // Debug entry and exit
  input  wire        debug_enter_i,
  input  wire        debug_exit_i,
  input  wire [31:0] cur_pc_i,
  // Memory or fetch access to watch
  input  wire        acc_valid_i,
  input  wire        acc_load_i,
  input  wire        acc_store_i,
  input  wire        acc_fetch_i,
  input  wire [1:0]  acc_priv_i,
  input  wire [31:0] acc_addr_i,
  // CSR answer
  output reg  [31:0] csr_rdata_o,
  output reg         csr_illegal_o,
  // Trigger actions and resume
  output reg         bkpt_exc_o,
  output reg         bkpt_debug_o,
  output reg         resume_o,
  output reg  [31:0] resume_pc_o
);

  // ----------------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------------
  reg  [31:0] tsel_r;
  reg  [31:0] dscratch_r;
  reg  [31:0] dcsr_r;
  wire [31:0] ctl0;
  wire [31:0] ctl1;
  wire [31:0] adr0;
  wire [31:0] adr1;
  wire        hit0;
  wire        hit1;
  wire [31:0] dpc;
  wire [31:0] sel_ctl;
  wire [31:0] sel_adr;
  wire        sel_dmode;
  wire        is_tdata;
  wire        is_dbgonly;
  reg         illegal;
  reg  [31:0] rdata;
  wire        wr_ok;
  wire        fire0;
  wire        fire1;
  wire [3:0]  act0;
  wire [3:0]  act1;

  // ----------------------------------------------------------------------
  // Access checking
  // ----------------------------------------------------------------------
  // The bank seen through the data addresses follows the select index.
  assign sel_ctl   = tsel_r[0] ? ctl1 : ctl0;            // [RL2] [RL10]
  assign sel_adr   = tsel_r[0] ? adr1 : adr0;            // [RL2] [RL11]
  assign sel_dmode = sel_ctl[`MC_DMODE];
  assign is_tdata  = (csr_sel_i == `SEL_TRIGGER_DATA1) |
                     (csr_sel_i == `SEL_TRIGGER_DATA2) |
                     (csr_sel_i == `SEL_TRIGGER_DATA3);
  assign is_dbgonly = (csr_sel_i == `SEL_DEBUG_CSR) |
                      (csr_sel_i == `SEL_DEBUG_PC)  |
                      (csr_sel_i == `SEL_DEBUG_SCRATCH);

  // Illegal: debug-only register outside debug mode, a debug-only
  // trigger touched from machine mode, or the unused selector 7.
  always @* begin
    illegal = 1'b0;
    if (is_dbgonly && !debug_mode_i)
      illegal = 1'b1;                                    // [RL1]
    if (is_tdata && sel_dmode && !debug_mode_i)
      illegal = 1'b1;                                    // [RL6] [RL7]
    if (csr_sel_i > `SEL_DEBUG_SCRATCH)
      illegal = 1'b1;
  end

  assign wr_ok = csr_en_i & csr_we_i & ~illegal;

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  always @* begin
    case (csr_sel_i)
      `SEL_TRIGGER_SELECT: rdata = tsel_r;
      `SEL_TRIGGER_DATA1:  rdata = sel_ctl;              // [RL5] [RL11]
      `SEL_TRIGGER_DATA2:  rdata = sel_adr;
      `SEL_TRIGGER_DATA3:  rdata = `ZERO32;              // [RL11]
      `SEL_DEBUG_CSR:      rdata = dcsr_r;
      `SEL_DEBUG_PC:       rdata = dpc;
      `SEL_DEBUG_SCRATCH:  rdata = dscratch_r;
      default:             rdata = `ZERO32;
    endcase
    if (illegal)
      rdata = `ZERO32;                                   // [RL22]
  end

  // ----------------------------------------------------------------------
  // Select, scratch and status registers
  // ----------------------------------------------------------------------
  // Out-of-range select writes keep the previous legal index.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tsel_r     <= `ZERO32;
      dscratch_r <= `ZERO32;
      dcsr_r     <= `ZERO32;
    end else if (wr_ok) begin
      case (csr_sel_i)
        `SEL_TRIGGER_SELECT: begin
          if (csr_wdata_i <= `LAST_INDEX)
            tsel_r <= csr_wdata_i;                       // [RL3] [RL23]
        end
        `SEL_DEBUG_CSR:     dcsr_r     <= csr_wdata_i;
        `SEL_DEBUG_SCRATCH: dscratch_r <= csr_wdata_i;
        default:            dcsr_r     <= dcsr_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Breakpoint instances
  // ----------------------------------------------------------------------
  bp_trigger u_bp0 (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .ctl_we_i    (wr_ok & (csr_sel_i == `SEL_TRIGGER_DATA1) & ~tsel_r[0]),
    .adr_we_i    (wr_ok & (csr_sel_i == `SEL_TRIGGER_DATA2) & ~tsel_r[0]),
    .wdata_i     (csr_wdata_i),
    .acc_valid_i (acc_valid_i),
    .acc_load_i  (acc_load_i),
    .acc_store_i (acc_store_i),
    .acc_fetch_i (acc_fetch_i),
    .acc_priv_i  (acc_priv_i),
    .acc_addr_i  (acc_addr_i),
    .ctl_o       (ctl0),
    .adr_o       (adr0),
    .hit_o       (hit0)
  );

  bp_trigger u_bp1 (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .ctl_we_i    (wr_ok & (csr_sel_i == `SEL_TRIGGER_DATA1) & tsel_r[0]),
    .adr_we_i    (wr_ok & (csr_sel_i == `SEL_TRIGGER_DATA2) & tsel_r[0]),
    .wdata_i     (csr_wdata_i),
    .acc_valid_i (acc_valid_i),
    .acc_load_i  (acc_load_i),
    .acc_store_i (acc_store_i),
    .acc_fetch_i (acc_fetch_i),
    .acc_priv_i  (acc_priv_i),
    .acc_addr_i  (acc_addr_i),
    .ctl_o       (ctl1),
    .adr_o       (adr1),
    .hit_o       (hit1)
  );

  // ----------------------------------------------------------------------
  // Debug PC
  // ----------------------------------------------------------------------
  dbg_pc_hold u_dpc (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .enter_i    (debug_enter_i),
    .pc_i       (cur_pc_i),
    .we_i       (wr_ok & (csr_sel_i == `SEL_DEBUG_PC)),
    .wdata_i    (csr_wdata_i),
    .dpc_o      (dpc)
  );

  // ----------------------------------------------------------------------
  // Chain and action decode
  // ----------------------------------------------------------------------
  // A chained lower trigger fires only with its partner; the partner then
  // never fires on its own.
  assign fire0 = ctl0[`MC_CHAIN] ? (hit0 & hit1) : hit0;  // [RL20]
  assign fire1 = ctl0[`MC_CHAIN] ? 1'b0 : hit1;           // [RL20]
  assign act0  = ctl0[`MC_ACT_HI:`MC_ACT_LO];
  assign act1  = ctl1[`MC_ACT_HI:`MC_ACT_LO];

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      csr_rdata_o   <= `ZERO32;
      csr_illegal_o <= 1'b0;
      bkpt_exc_o    <= 1'b0;
      bkpt_debug_o  <= 1'b0;
      resume_o      <= 1'b0;
      resume_pc_o   <= `ZERO32;
    end else begin
      csr_rdata_o   <= csr_en_i ? rdata : `ZERO32;
      csr_illegal_o <= csr_en_i & illegal;                // [RL1] [RL6]
      bkpt_exc_o    <= (fire0 & (act0 == `ACT_BKPT)) |
                       (fire1 & (act1 == `ACT_BKPT));     // [RL19]
      bkpt_debug_o  <= (fire0 & (act0 == `ACT_DEBUG)) |
                       (fire1 & (act1 == `ACT_DEBUG));    // [RL19]
      resume_o      <= debug_exit_i;                      // [RL8]
      resume_pc_o   <= dpc;                               // [RL8]
    end
  end

endmodule // hart_debug_trigger_csrs

// ===== rtl/dbg_trig_defs.vh
// Purpose: Constants for the per-hart debug and trigger register unit.
// Assumes: 32-bit registers, CSR-style access from the core pipeline.
// Notes:   Definitions only.
`ifndef DBG_TRIG_DEFS_VH
`define DBG_TRIG_DEFS_VH

// ----------------------------------------------------------------------
// Register selector codes on the core access port
// ----------------------------------------------------------------------
`define SEL_TRIGGER_SELECT 3'h0
`define SEL_TRIGGER_DATA1  3'h1
`define SEL_TRIGGER_DATA2  3'h2
`define SEL_TRIGGER_DATA3  3'h3
`define SEL_DEBUG_CSR      3'h4
`define SEL_DEBUG_PC       3'h5
`define SEL_DEBUG_SCRATCH  3'h6

// ----------------------------------------------------------------------
// Privilege encodings of the current access
// ----------------------------------------------------------------------
`define PRIV_USER  2'h0
`define PRIV_SUPER 2'h1
`define PRIV_MACH  2'h3

// ----------------------------------------------------------------------
// Match control field positions
// ----------------------------------------------------------------------
`define MC_LOAD      0
`define MC_STORE     1
`define MC_EXEC      2
`define MC_USER      3
`define MC_SUPER     4
`define MC_RSV5      5
`define MC_MACH      6
`define MC_MATCH_LO  7
`define MC_MATCH_HI  10
`define MC_CHAIN     11
`define MC_ACT_LO    12
`define MC_ACT_HI    15
`define MC_RSV20     20
`define MC_DMODE     27

// Writable bit mask: R,W,X,U,S,rsv5,M,match,chain,action,rsv20,dmode.
`define MC_WR_MASK   32'h0810_ffff
// Fixed read-only fields: type 2 in [31:28], maskmax 4 in [26:21].
`define MC_RO_BITS   32'h2080_0000

// ----------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------
`define TYPE_NONE    4'h0
`define ACT_BKPT     4'h0
`define ACT_DEBUG    4'h1
`define MATCH_EQUAL  4'h0
`define MATCH_NAPOT  4'h1
`define MATCH_GE     4'h2
`define MATCH_LT     4'h3
`define LAST_INDEX   32'h0000_0001
`define ZERO32       32'h0000_0000

`endif

// ===== rtl/bp_trigger.v
// Purpose: One address-match breakpoint: control, address and compare.
// Assumes: Writes arrive already checked for privilege by the parent.
// Notes:   Chain combining is done by the parent.
`timescale 1ns/100ps
`include "dbg_trig_defs.vh"

module bp_trigger (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        srst_i,
  // Register writes
  input  wire        ctl_we_i,
  input  wire        adr_we_i,
  input  wire [31:0] wdata_i,
  // Current access
  input  wire        acc_valid_i,
  input  wire        acc_load_i,
  input  wire        acc_store_i,
  input  wire        acc_fetch_i,
  input  wire [1:0]  acc_priv_i,
  input  wire [31:0] acc_addr_i,
  // State out
  output wire [31:0] ctl_o,
  output wire [31:0] adr_o,
  output wire        hit_o
);

  reg  [31:0] ctl_r;
  reg  [31:0] adr_r;
  reg  [31:0] napot_mask;
  reg         addr_ok;
  reg         type_ok;
  reg         priv_ok;
  wire [3:0]  match_sel = ctl_r[`MC_MATCH_HI:`MC_MATCH_LO];
  integer     i;
  reg         done;

  // ----------------------------------------------------------------------
  // Control and address registers
  // ----------------------------------------------------------------------
  // Only writable bits are stored; fixed fields are merged on read.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      ctl_r <= `ZERO32;                                  // [RL15]
      adr_r <= `ZERO32;
    end else begin
      if (ctl_we_i)
        ctl_r <= wdata_i & `MC_WR_MASK;                  // [RL12] [RL13] [RL14] [RL16]
      if (adr_we_i)
        adr_r <= wdata_i;
    end
  end

  assign ctl_o = ctl_r | `MC_RO_BITS;                    // [RL17] [RL18]
  assign adr_o = adr_r;

  // ----------------------------------------------------------------------
  // Address comparison
  // ----------------------------------------------------------------------
  // Trailing ones up to the first zero widen the NAPOT range.
  always @* begin
    napot_mask = `ZERO32;
    done       = 1'b0;
    for (i = 0; i < 31; i = i + 1) begin
      if (!done) begin
        napot_mask[i] = 1'b1;                            // [RL21]
        if (!adr_r[i])
          done = 1'b1;
      end
    end
    case (match_sel)
      `MATCH_EQUAL: addr_ok = (acc_addr_i == adr_r);
      `MATCH_NAPOT: addr_ok = ((acc_addr_i | napot_mask) == (adr_r | napot_mask)); // [RL21]
      `MATCH_GE:    addr_ok = (acc_addr_i >= adr_r);
      `MATCH_LT:    addr_ok = (acc_addr_i < adr_r);
      default:      addr_ok = 1'b0;
    endcase
    type_ok = (acc_load_i  & ctl_r[`MC_LOAD])  |
              (acc_store_i & ctl_r[`MC_STORE]) |
              (acc_fetch_i & ctl_r[`MC_EXEC]);
    case (acc_priv_i)
      `PRIV_USER:  priv_ok = ctl_r[`MC_USER];
      `PRIV_SUPER: priv_ok = ctl_r[`MC_SUPER];
      `PRIV_MACH:  priv_ok = ctl_r[`MC_MACH];
      default:     priv_ok = 1'b0;
    endcase
  end

  assign hit_o = acc_valid_i & type_ok & priv_ok & addr_ok; // [RL24]

endmodule // bp_trigger

// ===== rtl/dbg_pc_hold.v
// Purpose: Debug PC holder: captures PC on entry, gives resume PC.
// Assumes: Entry pulse and PC come from the pipeline in the same cycle.
// Notes:   Also writable through its CSR in debug mode.
`timescale 1ns/100ps
`include "dbg_trig_defs.vh"

module dbg_pc_hold (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        srst_i,
  // Capture and write
  input  wire        enter_i,
  input  wire [31:0] pc_i,
  input  wire        we_i,
  input  wire [31:0] wdata_i,
  // Held value
  output reg  [31:0] dpc_o
);

  // Entry capture wins over a software write in the same cycle.
  always @(posedge core_clk_i) begin
    if (srst_i)
      dpc_o <= `ZERO32;
    else if (enter_i)
      dpc_o <= pc_i;                                     // [RL8]
    else if (we_i)
      dpc_o <= wdata_i;
  end

endmodule // dbg_pc_hold

// ===== verification/core_model.sv
// Purpose: Core pipeline model issuing CSR, watched-access and debug events.
// Assumes: All requests change just after a rising edge and hold one cycle.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/100ps
module core_model (
  // Clock and CSR answer
  input  wire        core_clk_i,
  input  wire [31:0] csr_rdata_i,
  input  wire        csr_illegal_i,
  // CSR request
  output reg         csr_en_o,
  output reg         csr_we_o,
  output reg  [2:0]  csr_sel_o,
  output reg  [31:0] csr_wdata_o,
  // Mode, entry, exit and PC
  output reg         debug_mode_o,
  output reg         debug_enter_o,
  output reg         debug_exit_o,
  output reg  [31:0] cur_pc_o,
  // Watched access, kind is {fetch, store, load}
  output reg         acc_valid_o,
  output reg  [2:0]  acc_kind_o,
  output reg  [1:0]  acc_priv_o,
  output reg  [31:0] acc_addr_o
);
  // Every line starts quiet.
  initial begin
    {csr_en_o, csr_we_o, csr_sel_o, csr_wdata_o, debug_mode_o, debug_enter_o} = 0;
    {debug_exit_o, cur_pc_o, acc_valid_o, acc_kind_o, acc_priv_o, acc_addr_o} = 0;
  end

  // One CSR access; the answer is taken one cycle after the request.
  task csr(input w, input [2:0] s, input [31:0] d, output [31:0] q, output il);
    begin
      @(posedge core_clk_i);
      csr_en_o    <= 1'b1;
      csr_we_o    <= w;
      csr_sel_o   <= s;
      csr_wdata_o <= d;
      @(posedge core_clk_i);
      csr_en_o    <= 1'b0;
      csr_wdata_o <= ~d;
      #1;
      q  = csr_rdata_i;
      il = csr_illegal_i;
    end
  endtask

  // Switch between debug mode and machine mode.
  task mode(input m);
    begin
      @(posedge core_clk_i);
      debug_mode_o <= m;
    end
  endtask

  // Debug entry pulse with the PC to be saved.
  task enter(input [31:0] pc);
    begin
      @(posedge core_clk_i);
      debug_enter_o <= 1'b1;
      debug_mode_o  <= 1'b1;
      cur_pc_o      <= pc;
      @(posedge core_clk_i);
      debug_enter_o <= 1'b0;
      cur_pc_o      <= ~pc;
    end
  endtask

  // Debug exit pulse; returns just after the resume answer lands.
  task leave;
    begin
      @(posedge core_clk_i);
      debug_exit_o <= 1'b1;
      @(posedge core_clk_i);
      debug_exit_o <= 1'b0;
      debug_mode_o <= 1'b0;
      #1;
    end
  endtask

  // One watched access; returns just after the trigger answer lands.
  task acc(input [2:0] k, input [1:0] p, input [31:0] a);
    begin
      @(posedge core_clk_i);
      acc_valid_o <= 1'b1;
      acc_kind_o  <= k;
      acc_priv_o  <= p;
      acc_addr_o  <= a;
      @(posedge core_clk_i);
      acc_valid_o <= 1'b0;
      acc_addr_o  <= ~a;
      #1;
    end
  endtask
endmodule // core_model

// ===== verification/hart_debug_trigger_csrs_properties.sv
// Purpose: Port-level properties of the debug and trigger register unit.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached to the unit by bind at the foot of this file.
`timescale 1ns/100ps
`include "dbg_trig_defs.vh"
module hart_debug_trigger_csrs_props (
  // Watched ports
  input  wire        core_clk_i,
  input  wire        srst_i,
  input  wire        csr_en_i,
  input  wire        csr_we_i,
  input  wire [2:0]  csr_sel_i,
  input  wire        debug_mode_i,
  input  wire        debug_enter_i,
  input  wire        debug_exit_i,
  input  wire [31:0] cur_pc_i,
  input  wire        acc_valid_i,
  input  wire        acc_load_i,
  input  wire        acc_store_i,
  input  wire        acc_fetch_i,
  input  wire [31:0] csr_rdata_o,
  input  wire        csr_illegal_o,
  input  wire        bkpt_exc_o,
  input  wire        bkpt_debug_o,
  input  wire        resume_o,
  input  wire [31:0] resume_pc_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire rd = csr_en_i && !csr_we_i;

  dbg_only_a: assert property (csr_en_i && csr_sel_i >= 3'h4 && !debug_mode_i |=>
    csr_illegal_o && csr_rdata_o == 32'h0) else $error("debug-only register reached");
  sel_legal_a: assert property (rd && csr_sel_i == `SEL_TRIGGER_SELECT |=>
    !csr_illegal_o && csr_rdata_o[31:1] == 31'h0) else $error("select index out of range");
  type_two_a: assert property (rd && csr_sel_i == `SEL_TRIGGER_DATA1 && debug_mode_i |=>
    csr_rdata_o[31:28] == 4'h2 && csr_rdata_o[26:21] == 6'h04) else $error("fixed fields wrong");
  fixed_zero_a: assert property (rd && csr_sel_i == `SEL_TRIGGER_DATA1 |=>
    csr_rdata_o[19:16] == 4'h0) else $error("size, timing or select not zero");
  data3_zero_a: assert property (rd && csr_sel_i == `SEL_TRIGGER_DATA3 && debug_mode_i |=>
    csr_rdata_o == 32'h0 && !csr_illegal_o) else $error("third data register not zero");
  resume_go_a: assert property (debug_exit_i |=> resume_o) else $error("no resume");
  dpc_save_a: assert property (debug_enter_i |-> ##2 resume_pc_o == $past(cur_pc_i, 2))
    else $error("entry PC not kept");
  idle_quiet_a: assert property (!acc_valid_i |=> !bkpt_exc_o && !bkpt_debug_o)
    else $error("trigger fired without access");
  no_kind_a: assert property (!(acc_load_i || acc_store_i || acc_fetch_i) |=>
    !bkpt_exc_o && !bkpt_debug_o) else $error("trigger fired without access kind");
  one_action_a: assert property (!(bkpt_exc_o && bkpt_debug_o))
    else $error("two actions at once");
endmodule // hart_debug_trigger_csrs_props

bind hart_debug_trigger_csrs hart_debug_trigger_csrs_props i_props (.core_clk_i, .srst_i,
  .csr_en_i, .csr_we_i, .csr_sel_i, .debug_mode_i, .debug_enter_i, .debug_exit_i, .cur_pc_i,
  .acc_valid_i, .acc_load_i, .acc_store_i, .acc_fetch_i, .csr_rdata_o, .csr_illegal_o,
  .bkpt_exc_o, .bkpt_debug_o, .resume_o, .resume_pc_o);

// ===== verification/hart_debug_trigger_csrs_tb.sv
// Purpose: Self-checking bench for the debug and trigger register unit.
// Assumes: The core model drives every input of the unit except clock and reset.
// Notes:   Each scenario is one task that judges what comes back.
`timescale 1ns/100ps
`include "dbg_trig_defs.vh"
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, (g), (e)); end end
module hart_debug_trigger_csrs_tb;
  reg         core_clk_i = 1'b0;
  reg         srst_i     = 1'b1;
  integer     n_fail     = 0;
  integer     checked    = 0;
  reg  [31:0] q;
  reg         il;
  wire        csr_en_i, csr_we_i, debug_mode_i, debug_enter_i, debug_exit_i, acc_valid_i;
  wire [2:0]  csr_sel_i, kind;
  wire [1:0]  acc_priv_i;
  wire [31:0] csr_wdata_i, cur_pc_i, acc_addr_i, csr_rdata_o, resume_pc_o;
  wire        csr_illegal_o, bkpt_exc_o, bkpt_debug_o, resume_o;

  // Clock of 100 ns.
  always #50 core_clk_i = ~core_clk_i;

  core_model i_core (.core_clk_i, .csr_rdata_i(csr_rdata_o), .csr_illegal_i(csr_illegal_o),
    .csr_en_o(csr_en_i), .csr_we_o(csr_we_i), .csr_sel_o(csr_sel_i), .csr_wdata_o(csr_wdata_i),
    .debug_mode_o(debug_mode_i), .debug_enter_o(debug_enter_i), .debug_exit_o(debug_exit_i),
    .cur_pc_o(cur_pc_i), .acc_valid_o(acc_valid_i), .acc_kind_o(kind),
    .acc_priv_o(acc_priv_i), .acc_addr_o(acc_addr_i));
  hart_debug_trigger_csrs i_dut (.core_clk_i, .srst_i, .csr_en_i, .csr_we_i, .csr_sel_i,
    .csr_wdata_i, .debug_mode_i, .debug_enter_i, .debug_exit_i, .cur_pc_i, .acc_valid_i,
    .acc_load_i(kind[0]), .acc_store_i(kind[1]), .acc_fetch_i(kind[2]), .acc_priv_i,
    .acc_addr_i, .csr_rdata_o, .csr_illegal_o, .bkpt_exc_o, .bkpt_debug_o, .resume_o,
    .resume_pc_o);

  // Print the verdict and end the run.
  task stop_test;
    begin
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Write or read one register.
  task wr(input [2:0] s, input [31:0] d);
    i_core.csr(1'b1, s, d, q, il);
  endtask
  task rd(input [2:0] s);
    i_core.csr(1'b0, s, 32'h0, q, il);
  endtask

  // Load one breakpoint with control and address.
  task prog(input [31:0] idx, input [31:0] ctl, input [31:0] adr);
    begin
      wr(`SEL_TRIGGER_SELECT, idx);
      wr(`SEL_TRIGGER_DATA1, ctl);
      wr(`SEL_TRIGGER_DATA2, adr);
    end
  endtask

  // One watched access and its expected actions.
  task hit(input [2:0] k, input [1:0] p, input [31:0] a, input ee, input ed);
    begin
      i_core.acc(k, p, a);
      `CHK(bkpt_exc_o, ee)
      `CHK(bkpt_debug_o, ed)
    end
  endtask

  // Reset values, select legalising and bank steering.
  task t_select;
    begin
      i_core.mode(1'b1);
      rd(`SEL_TRIGGER_SELECT);
      `CHK(q, 32'h0)
      rd(`SEL_TRIGGER_DATA1);
      `CHK(q, 32'h2080_0000)
      wr(`SEL_TRIGGER_SELECT, 32'h1);
      wr(`SEL_TRIGGER_SELECT, 32'h5);
      rd(`SEL_TRIGGER_SELECT);
      `CHK(q, 32'h1)
      rd(`SEL_TRIGGER_DATA1);
      `CHK(q[31:28], 4'h2)
      wr(`SEL_TRIGGER_DATA2, 32'h11);
      wr(`SEL_TRIGGER_DATA3, 32'h33);
      rd(`SEL_TRIGGER_DATA3);
      `CHK(q, 32'h0)
      prog(32'h0, 32'h0, 32'h22);
      rd(`SEL_TRIGGER_DATA2);
      `CHK(q, 32'h22)
      wr(`SEL_TRIGGER_SELECT, 32'h1);
      rd(`SEL_TRIGGER_DATA2);
      `CHK(q, 32'h11)
    end
  endtask

  // Field masks and the debug-only claim on a trigger.
  task t_fields;
    begin
      prog(32'h0, 32'hffff_ffff, 32'h22);
      rd(`SEL_TRIGGER_DATA1);
      `CHK(q, 32'h2890_ffff)
      i_core.mode(1'b0);
      rd(`SEL_TRIGGER_DATA1);
      `CHK(il, 1'b1)
      `CHK(q, 32'h0)
      wr(`SEL_TRIGGER_DATA2, 32'h55);
      `CHK(il, 1'b1)
      rd(`SEL_TRIGGER_SELECT);
      `CHK(il, 1'b0)
      i_core.mode(1'b1);
      rd(`SEL_TRIGGER_DATA2);
      `CHK(q, 32'h22)
      wr(`SEL_TRIGGER_DATA1, 32'h0);
    end
  endtask

  // Debug-only registers, scratch use and the saved PC.
  task t_debug_regs;
    integer s;
    begin
      i_core.mode(1'b0);
      for (s = 4; s < 8; s = s + 1) begin
        rd(s[2:0]);
        `CHK(il, 1'b1)
      end
      i_core.enter(32'h8000_1234);
      wr(`SEL_DEBUG_SCRATCH, 32'hdead_beef);
      rd(`SEL_DEBUG_SCRATCH);
      `CHK(q, 32'hdead_beef)
      rd(`SEL_DEBUG_PC);
      `CHK(q, 32'h8000_1234)
      wr(`SEL_DEBUG_PC, 32'h400);
      i_core.leave;
      `CHK(resume_o, 1'b1)
      `CHK(resume_pc_o, 32'h400)
    end
  endtask

  // Kind, privilege, match types, chaining and actions.
  task t_match;
    begin
      prog(32'h0, 32'h41, 32'h1000);
      hit(3'h1, 2'h3, 32'h1000, 1'b1, 1'b0);
      hit(3'h1, 2'h3, 32'h1001, 1'b0, 1'b0);
      hit(3'h2, 2'h3, 32'h1000, 1'b0, 1'b0);
      hit(3'h0, 2'h3, 32'h1000, 1'b0, 1'b0);
      hit(3'h1, 2'h0, 32'h1000, 1'b0, 1'b0);
      prog(32'h0, 32'h101c, 32'h1000);
      hit(3'h4, 2'h0, 32'h1000, 1'b0, 1'b1);
      hit(3'h4, 2'h1, 32'h1000, 1'b0, 1'b1);
      hit(3'h4, 2'h3, 32'h1000, 1'b0, 1'b0);
      prog(32'h0, 32'hc1, 32'h1003);
      hit(3'h1, 2'h3, 32'h1007, 1'b1, 1'b0);
      hit(3'h1, 2'h3, 32'h1008, 1'b0, 1'b0);
      prog(32'h0, 32'h941, 32'h2000);
      prog(32'h1, 32'h1c1, 32'h2010);
      hit(3'h1, 2'h3, 32'h2008, 1'b1, 1'b0);
      hit(3'h1, 2'h3, 32'h2010, 1'b0, 1'b0);
      hit(3'h1, 2'h3, 32'h1ff0, 1'b0, 1'b0);
      prog(32'h0, 32'h2041, 32'h3000);
      hit(3'h1, 2'h3, 32'h3000, 1'b0, 1'b0);
    end
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_select;
    t_fields;
    t_debug_regs;
    t_match;
    stop_test;
  end

  // Watchdog, far beyond the 150 or so cycles the tests need.
  initial begin
    #500000;
    n_fail = n_fail + 1;
    stop_test;
  end
endmodule // hart_debug_trigger_csrs_tb
